// ==== logic/uhbp_top.sv ====
// Purpose: Host parallel bus port of a single channel UART
// Assumes: All pins synchronous to SYS_CLK; core register file outside
// Notes: Register reads see REG_RD_DATA in the cycle REG_RD is high
//
// What this block does
// - Three select lines pick one register
// - Drive data bus only on reads
// - Strobe mode: read fall starts read
// - Strobe mode: write fall begins, rise loads byte
// - Direction mode ignores read strobe
// - Direction mode: write pin is read/write
// - Start accesses only while chip select low
// - Strobe mode irq high, enabled by control bit
// - Direction mode irq low, open drain
// - Four power modes, hardware or software
// - Power-save ignores all bus pins
// - Wake interrupt on leaving low power
`timescale 1ns/100ps
module uhbp_top
    import uhbp_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input wire logic BUS_STYLE,
    input wire logic CS_N,
    input wire logic READ_STROBE_N,
    input wire logic WRITE_STROBE_N,
    input wire logic [uhbp_pkg::SEL_W-1:0] REG_SELECT,
    input wire logic [uhbp_pkg::DATA_W-1:0] HOST_DATA_I,
    output logic [uhbp_pkg::DATA_W-1:0] HOST_DATA_O,
    output logic HOST_DATA_OE,
    output logic INT_O,
    output logic INT_OE,
    output logic [uhbp_pkg::SEL_W-1:0] REG_ADDR,
    output logic REG_RD,
    input wire logic [uhbp_pkg::DATA_W-1:0] REG_RD_DATA,
    output logic REG_WR,
    output logic [uhbp_pkg::DATA_W-1:0] REG_WR_DATA,
    input wire logic [uhbp_pkg::DATA_W-1:0] MODEM_CONTROL_REG,
    input wire logic INT_PENDING,
    input wire logic PWR_HW_EN,
    input wire logic [uhbp_pkg::MODE_W-1:0] PWR_HW_MODE,
    input wire logic [uhbp_pkg::MODE_W-1:0] PWR_SW_MODE,
    output logic [uhbp_pkg::MODE_W-1:0] PWR_MODE,
    output logic WAKE_PENDING,
    input wire logic WAKE_ACK
);
    import uhbp_pkg::*;

    logic [EDGE_N-1:0] pin_fall;
    logic [EDGE_N-1:0] pin_rise;
    uhbp_state_t state_r;
    uhbp_state_t state_nxt;
    uhbp_pwr_t pwr_r;
    uhbp_pwr_t pwr_nxt;
    logic [SEL_W-1:0] addr_r;
    logic rd_r;
    logic wr_r;
    logic [DATA_W-1:0] rd_data_r;
    logic [DATA_W-1:0] wr_data_r;
    logic wake_r;
    logic int_o_r;
    logic int_oe_r;

    uhbp_edge #(.WIDTH(EDGE_N)) u_edge (
        .SYS_CLK(SYS_CLK),
        .RSTN(RSTN),
        .PIN_N({WRITE_STROBE_N, READ_STROBE_N, CS_N}),
        .FALL(pin_fall),
        .RISE(pin_rise)
    );

    // Power mode: hardware pins override the software code
    assign pwr_nxt = uhbp_pwr_t'(PWR_HW_EN ? PWR_HW_MODE : PWR_SW_MODE);
    wire psave = (pwr_r == PM_PSAVE);
    wire strobe_style = BUS_STYLE;
    wire selected = ~CS_N & ~psave;

    // Direction mode frames an access with chip select; read strobe unused
    wire rd_start = selected & (strobe_style ? pin_fall[EDGE_RD]
                                             : pin_fall[EDGE_CS] & WRITE_STROBE_N);
    wire wr_start = selected & (strobe_style ? pin_fall[EDGE_WR]
                                             : pin_fall[EDGE_CS] & ~WRITE_STROBE_N);
    wire wr_commit = (state_r == ST_WRITE) & ~psave
                   & (strobe_style ? pin_rise[EDGE_WR] & ~CS_N : pin_rise[EDGE_CS]);
    wire rd_end = strobe_style ? (pin_rise[EDGE_RD] | CS_N) : pin_rise[EDGE_CS];
    wire wr_abort = psave | (strobe_style & CS_N);
    wire irq = INT_PENDING | wake_r;
    wire int_en = MODEM_CONTROL_REG[MCR_INT_EN_BIT];

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (rd_start) begin
                    state_nxt = ST_READ;
                end else if (wr_start) begin
                    state_nxt = ST_WRITE;
                end
            end
            ST_READ: begin
                if (rd_end | psave) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_WRITE: begin
                if (wr_commit | wr_abort) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_r <= ST_IDLE;
            addr_r <= SEL_RST;
            rd_r <= 1'b0;
            wr_r <= 1'b0;
            wr_data_r <= DATA_RST;
        end else begin
            state_r <= state_nxt;
            rd_r <= rd_start && state_r == ST_IDLE;
            wr_r <= wr_commit;
            if (state_r == ST_IDLE && (rd_start || wr_start)) begin
                addr_r <= REG_SELECT;
            end
            if (wr_commit) begin
                wr_data_r <= HOST_DATA_I;
            end
        end
    end

    // Read byte held until the next register read pulse
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rd_data_r <= DATA_RST;
        end else if (rd_r) begin
            rd_data_r <= REG_RD_DATA;
        end
    end

    // Set beats acknowledge so a wake in the ack cycle is kept
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            pwr_r <= PM_ACTIVE;
            wake_r <= 1'b0;
        end else begin
            pwr_r <= pwr_nxt;
            if (pwr_r != PM_ACTIVE && pwr_nxt == PM_ACTIVE) begin
                wake_r <= 1'b1;
            end else if (WAKE_ACK) begin
                wake_r <= 1'b0;
            end
        end
    end

    // Open-drain form only ever drives low
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            int_o_r <= 1'b0;
            int_oe_r <= 1'b0;
        end else begin
            int_o_r <= strobe_style & irq;
            int_oe_r <= strobe_style ? int_en : irq;
        end
    end

    assign HOST_DATA_O = rd_data_r;
    assign HOST_DATA_OE = (state_r == ST_READ) & selected;
    assign INT_O = int_o_r;
    assign INT_OE = int_oe_r;
    assign REG_ADDR = addr_r;
    assign REG_RD = rd_r;
    assign REG_WR = wr_r;
    assign REG_WR_DATA = wr_data_r;
    assign PWR_MODE = pwr_r;
    assign WAKE_PENDING = wake_r;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);

    a_rd_pulse_start: assert property (rd_start && state_r == ST_IDLE |=> REG_RD && REG_ADDR == $past(REG_SELECT))
        else $error("Read start did not pulse REG_RD with address");
    a_rd_ignored_dir: assert property (!BUS_STYLE && state_r == ST_IDLE && CS_N |=> !REG_RD)
        else $error("Read issued while deselected in direction mode");
    a_wr_on_rise: assert property (BUS_STYLE && state_r == ST_WRITE && pin_rise[EDGE_WR] && !CS_N && !psave
                                   |=> REG_WR && REG_WR_DATA == $past(HOST_DATA_I))
        else $error("Write strobe rise did not load data");
    a_dir_write: assert property (!BUS_STYLE && state_r == ST_WRITE && pin_rise[EDGE_CS] && !psave |=> REG_WR)
        else $error("Direction write not committed at deselect");
    a_oe_only_sel: assert property (HOST_DATA_OE |-> !CS_N && !psave && state_r == ST_READ)
        else $error("Data bus driven outside a selected read");
    a_wr_no_fall: assert property (!BUS_STYLE && !WRITE_STROBE_N && CS_N && state_r == ST_IDLE |=> !REG_WR [*2])
        else $error("Write without chip select");
    a_int_strobe: assert property (BUS_STYLE && $stable(BUS_STYLE) |=> INT_OE == $past(int_en))
        else $error("Strobe mode irq enable does not follow control bit");
    a_int_od: assert property (!BUS_STYLE |=> !INT_O && INT_OE == $past(irq))
        else $error("Open-drain irq misdriven");
    a_psave_quiet: assert property (psave && state_r == ST_IDLE |=> !REG_RD && !REG_WR && !HOST_DATA_OE)
        else $error("Bus activity accepted in power-save");
    a_wake_set: assert property (pwr_r != PM_ACTIVE && pwr_nxt == PM_ACTIVE |=> WAKE_PENDING [*1] ##1 1)
        else $error("Wake not raised on leaving low power");
    a_mode_follow: assert property (1'b1 |=> PWR_MODE == ($past(PWR_HW_EN) ? $past(PWR_HW_MODE) : $past(PWR_SW_MODE)))
        else $error("Power mode not taken from selected source");
    a_rd_data_load: assert property (REG_RD |=> HOST_DATA_O == $past(REG_RD_DATA))
        else $error("Read byte not captured from core");
    a_rd_pulse_one: assert property (REG_RD |=> !REG_RD)
        else $error("Register read pulse longer than one cycle");
    a_wr_pulse_one: assert property (REG_WR |=> !REG_WR)
        else $error("Register write pulse longer than one cycle");
    a_rd_strobe_unused: assert property (!BUS_STYLE && state_r == ST_IDLE && !pin_fall[EDGE_CS] |=> !REG_RD)
        else $error("Read started without chip select fall in direction mode");

    c_strobe_read: cover property (BUS_STYLE && REG_RD ##[1:8] HOST_DATA_OE);
    c_strobe_write: cover property (BUS_STYLE && REG_WR);
    c_dir_write: cover property (!BUS_STYLE && REG_WR);
    c_dir_read: cover property (!BUS_STYLE && REG_RD);
    c_wake: cover property ($rose(WAKE_PENDING));
endmodule : uhbp_top

// ==== logic/uhbp_pkg.sv ====
// Purpose: Shared constants and types for the UART host bus port
// Assumes: 8-bit host data, 3-bit register select
// Notes: Power mode order fixes the software and hardware mode code
package uhbp_pkg;
    localparam int DATA_W = 8;
    localparam int SEL_W = 3;
    localparam int MODE_W = 2;
    localparam int MCR_INT_EN_BIT = 3;
    localparam int EDGE_CS = 0;
    localparam int EDGE_RD = 1;
    localparam int EDGE_WR = 2;
    localparam int EDGE_N = 3;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic [SEL_W-1:0] SEL_RST = 3'h0;
    typedef enum logic [MODE_W-1:0] {PM_ACTIVE, PM_PARTIAL, PM_FULL, PM_PSAVE} uhbp_pwr_t;
    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} uhbp_state_t;
endpackage : uhbp_pkg

// ==== logic/uhbp_edge.sv ====
// Purpose: Edge finder for the active-low bus control pins
// Assumes: Inputs already synchronous to SYS_CLK
// Notes: History resets high, the idle level of every strobe
`timescale 1ns/100ps
module uhbp_edge #(
    parameter int WIDTH = 3
) (
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input wire logic [WIDTH-1:0] PIN_N,
    output logic [WIDTH-1:0] FALL,
    output logic [WIDTH-1:0] RISE
);
    logic [WIDTH-1:0] prev_r;

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            prev_r <= '1;
        end else begin
            prev_r <= PIN_N;
        end
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_edge
            assign FALL[i] = prev_r[i] & ~PIN_N[i];
            assign RISE[i] = ~prev_r[i] & PIN_N[i];
        end
    endgenerate
endmodule : uhbp_edge

// ==== verification/uhbp_core_model.sv ====
// Purpose: Register file stand-in behind the host bus port
// Assumes: Read data answers in the same cycle as the address
// Notes: Reset contents are arbitrary, distinct per register
`timescale 1ns/100ps
module uhbp_core_model
    import uhbp_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input wire logic [uhbp_pkg::SEL_W-1:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [uhbp_pkg::DATA_W-1:0] REG_WR_DATA,
    output logic [uhbp_pkg::DATA_W-1:0] REG_RD_DATA
);
    logic [DATA_W-1:0] mem [8];
    assign REG_RD_DATA = mem[REG_ADDR];
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            for (int i = 0; i < 8; i++) mem[i] <= 8'(i * 17);
        end else if (REG_WR) begin
            mem[REG_ADDR] <= REG_WR_DATA;
        end
    end
endmodule : uhbp_core_model

// ==== verification/uart_host_bus_port_tb.sv ====
// Purpose: Self-checking bench for the host bus port
// Assumes: Bench acts as host; inputs change on falling edge
// Notes: Bus style is changed only while the port is idle
`timescale 1ns/100ps
module uart_host_bus_port_tb;
    import uhbp_pkg::*;
    logic sys_clk, rstn, bus_style, cs_n, read_strobe_n, write_strobe_n, int_pending, pwr_hw_en, wake_ack;
    logic [SEL_W-1:0] reg_select, reg_addr;
    logic [DATA_W-1:0] data_i, data_o, rd_data, wr_data, modem_control_reg, q;
    logic data_oe, int_o, int_oe, reg_wr, reg_rd, wake_pending, oe;
    int n_rd = 0;
    logic [MODE_W-1:0] hw_mode, sw_mode, pwr_mode;
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;
    uhbp_top dut_u (.SYS_CLK(sys_clk), .RSTN(rstn), .BUS_STYLE(bus_style), .CS_N(cs_n),
        .READ_STROBE_N(read_strobe_n), .WRITE_STROBE_N(write_strobe_n), .REG_SELECT(reg_select),
        .HOST_DATA_I(data_i), .HOST_DATA_O(data_o), .HOST_DATA_OE(data_oe), .INT_O(int_o), .INT_OE(int_oe),
        .REG_ADDR(reg_addr), .REG_RD(reg_rd), .REG_RD_DATA(rd_data), .REG_WR(reg_wr), .REG_WR_DATA(wr_data),
        .MODEM_CONTROL_REG(modem_control_reg), .INT_PENDING(int_pending), .PWR_HW_EN(pwr_hw_en), .PWR_HW_MODE(hw_mode),
        .PWR_SW_MODE(sw_mode), .PWR_MODE(pwr_mode), .WAKE_PENDING(wake_pending), .WAKE_ACK(wake_ack));
    uhbp_core_model core_u (.SYS_CLK(sys_clk), .RSTN(rstn), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
        .REG_WR_DATA(wr_data), .REG_RD_DATA(rd_data));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // Pulses counted on the falling clock edge
    always @(negedge sys_clk) begin
        if (reg_rd) begin
            n_rd++;
        end
    end
    // Ceiling well above the few hundred cycles the run needs
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            end_of_test();
        end
    end
    task automatic end_of_test;
        if (n_fail == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // One access; in strobe mode strobes released before chip select so a write commits
    task automatic acc(input logic wr, input logic [2:0] sel, input logic [7:0] d, input logic cs);
        @(negedge sys_clk);
        n_rd = 0;
        cs_n = cs;
        reg_select = sel;
        data_i = d;
        write_strobe_n = !wr;
        if (bus_style) read_strobe_n = wr;
        repeat (3) @(negedge sys_clk);
        q = data_o;
        oe = data_oe;
        read_strobe_n = 1'b1;
        if (bus_style) write_strobe_n = 1'b1;
        @(negedge sys_clk);
        cs_n = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk("oe_idle", 8'(data_oe), 8'h00);
        write_strobe_n = 1'b1;
        data_i = ~d;
    endtask : acc
    task automatic t_strobe;
        for (int s = 0; s < 8; s++) begin
            acc(1'b1, 3'(s), 8'hc3 ^ 8'(s), 1'b0);
            chk("wr_oe", 8'(oe), 8'h00);
            chk("wr_no_rd", 8'(n_rd), 8'h00);
        end
        for (int s = 0; s < 8; s++) begin
            acc(1'b0, 3'(s), 8'h5a, 1'b0);
            chk("rd_data", q, 8'hc3 ^ 8'(s));
            chk("rd_oe", 8'(oe), 8'h01);
            chk("rd_pulse", 8'(n_rd), 8'h01);
        end
        acc(1'b1, 3'h4, 8'h77, 1'b1);
        chk("cs_wr", core_u.mem[4], 8'hc7);
        acc(1'b0, 3'h4, 8'h00, 1'b1);
        chk("cs_rd_oe", 8'(oe), 8'h00);
        chk("cs_rd", 8'(n_rd), 8'h00);
    endtask : t_strobe
    task automatic t_direction;
        bus_style = 1'b0;
        read_strobe_n = 1'b0;
        acc(1'b1, 3'h6, 8'h3c, 1'b0);
        chk("dir_wr", core_u.mem[6], 8'h3c);
        chk("dir_wr_rd", 8'(n_rd), 8'h00);
        acc(1'b0, 3'h6, 8'h00, 1'b0);
        chk("dir_rd", q, 8'h3c);
        chk("dir_oe", 8'(oe), 8'h01);
        chk("dir_rd_pulse", 8'(n_rd), 8'h01);
        acc(1'b1, 3'h6, 8'h99, 1'b1);
        chk("dir_cs", core_u.mem[6], 8'h3c);
    endtask : t_direction
    task automatic t_irq;
        modem_control_reg = 8'h00;
        int_pending = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk("od_lvl", 8'(int_o), 8'h00);
        chk("od_en", 8'(int_oe), 8'h01);
        int_pending = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk("od_off", 8'(int_oe), 8'h00);
        bus_style = 1'b1;
        modem_control_reg = 8'h08;
        int_pending = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk("irq_lvl", {int_oe, int_o}, 8'h03);
        modem_control_reg = 8'h00;
        repeat (2) @(negedge sys_clk);
        chk("irq_z", 8'(int_oe), 8'h00);
        int_pending = 1'b0;
        modem_control_reg = 8'h08;
    endtask : t_irq
    task automatic wake(input string what);
        repeat (2) @(negedge sys_clk);
        chk(what, {int_o, wake_pending}, 8'h03);
        wake_ack = 1'b1;
        @(negedge sys_clk);
        wake_ack = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk("wake_clr", {int_o, wake_pending}, 8'h00);
    endtask : wake
    task automatic t_power;
        sw_mode = PM_PSAVE;
        repeat (2) @(negedge sys_clk);
        chk("sw_mode", 8'(pwr_mode), 8'h03);
        acc(1'b1, 3'h2, 8'he1, 1'b0);
        chk("ps_wr", core_u.mem[2], 8'hc1);
        acc(1'b0, 3'h2, 8'h00, 1'b0);
        chk("ps_oe", 8'(oe), 8'h00);
        chk("ps_rd", 8'(n_rd), 8'h00);
        sw_mode = PM_ACTIVE;
        wake("wake_sw");
        pwr_hw_en = 1'b1;
        for (int m = 1; m < 4; m++) begin
            hw_mode = 2'(m);
            repeat (2) @(negedge sys_clk);
            chk("hw_mode", 8'(pwr_mode), 8'(m));
            hw_mode = PM_ACTIVE;
            wake("wake_hw");
        end
    endtask : t_power
    // Mid-run reset with a wake pending; core model contents return to reset values
    task automatic t_reset;
        hw_mode = PM_PARTIAL;
        repeat (2) @(negedge sys_clk);
        hw_mode = PM_ACTIVE;
        repeat (2) @(negedge sys_clk);
        chk("pre_rst", 8'(wake_pending), 8'h01);
        rstn = 1'b0;
        @(negedge sys_clk);
        chk("rst_out", {int_o, wake_pending, pwr_mode}, 8'h00);
        rstn = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk("rst_wake", 8'(wake_pending), 8'h00);
        acc(1'b0, 3'h5, 8'h00, 1'b0);
        chk("rst_rd", q, 8'h55);
        chk("rst_rd_n", 8'(n_rd), 8'h01);
    endtask : t_reset
    initial begin
        {rstn, int_pending, pwr_hw_en, wake_ack, hw_mode, sw_mode, reg_select, data_i, modem_control_reg} = '0;
        {bus_style, cs_n, read_strobe_n, write_strobe_n} = 4'hf;
        repeat (2) @(negedge sys_clk);
        rstn = 1'b1;
        repeat (2) @(negedge sys_clk);
        t_strobe();
        t_direction();
        t_irq();
        t_power();
        t_reset();
        end_of_test();
    end
endmodule : uart_host_bus_port_tb
